// [src/tcm_pkg.sv]
// constants for the triggered capture memory addressing block
// assumes a single 25 MHz system clock and a wishbone classic register port
package tcm_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DATA = 8'h04;
  localparam logic [7:0] REG_TRIG_ADDR = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_POST = 8'h10;
  localparam logic [7:0] REG_ADDR = 8'h14;
  localparam logic [7:0] REG_LEVEL = 8'h18;
  localparam logic [7:0] REG_RAM = 8'h1c;
  localparam int ARM_BIT = 1;
  localparam int WRITE_MODE_BIT = 2;
  localparam int ADDR_LOAD_BIT = 6;
  localparam int POST_LOAD_BIT = 7;
  localparam int READ_GATE_BIT = 9;
  localparam int MEM_READ_BIT = 10;
  localparam int LEVEL_LSB = 2;
  localparam logic [15:0] CTRL_RESET = 16'hffc1;
  localparam logic [15:0] POST_TERMINAL = 16'hffff;
  localparam logic [15:0] POST_RESET = 16'hffff;
  localparam logic [14:0] ADDR_RESET = 15'h0000;
  localparam logic [7:0] LEVEL_RESET = 8'h00;
  localparam int ADDR_W = 15;
  localparam int DEPTH = 32768;
  typedef enum logic [2:0] {
    ST_READ = 3'b001,
    ST_ARMED = 3'b010,
    ST_POST = 3'b100
  } tcm_state_t;
endpackage

// [src/tcm_sample_ram.sv]
// sample memory, one write port and one registered read port
// assumes both ports run on sys_clk
`timescale 1ns/100ps
`default_nettype none
module tcm_sample_ram
#(
  parameter int AW = 15,
  parameter int DW = 8
)
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wr_data,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[addr] <= wr_data;
    end
    rd_data <= mem[addr];
  end
endmodule
`default_nettype wire

// [src/tcm_capture.sv]
// capture addressing: post-trigger counter, circular address, trigger latch,
// video level comparator, wishbone classic register port
// assumes samples and trigger are synchronous to sys_clk
// What this block does
// R1: sixteen-bit post-trigger counter limits post-trigger writes
// R2: host loads post count with bits 7,9 low
// R3: post counter takes load value on clock
// R4: post counter counts up after count_run_n low
// R5: post counter advances once per sample
// R6: terminal count drives capture_stop_n low
// R7: capture_stop_n low forces count_run_n high
// R8: fifteen-bit address counter wraps circularly
// R9: trigger latches current ram address
// R10: address load with bits 6,9 low
// R11: host reads ram with bits 10,9 low
// R12: each ram read post-increments address counter
// R13: address increments only while capture_stop_n high
// R14: host reloads post count to release stop
// R15: eight-bit magnitude compare against trigger level
// R16: level latched from data bits 2 to 7
// R17: above, below, or both low when equal
// R18: comparator outputs clock video trigger generator
// R19: trigger needs arm, rearm after each trigger
// R20: samples written until terminal count
// R21: load and read gate bits 6,7,9,10 are active low; arm bit 1 and write mode bit 2 are active high
`timescale 1ns/100ps
`default_nettype none
module tcm_capture
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic sample_tick,
  input wire logic [7:0] sample_data,
  input wire logic trigger_in,
  output logic level_above,
  output logic level_below,
  output logic capture_stop_n,
  output logic count_run_n,
  output logic [tcm_pkg::ADDR_W-1:0] ram_addr
);
  import tcm_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // wishbone decode
  // ----------------------------------------------------------------
  logic [15:0] ctrl_reg;
  logic [15:0] post_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] trig_addr_reg;
  logic [7:0] level_reg;
  logic [7:0] ram_rd;
  logic ack_reg;
  logic req;
  logic wr_req;
  logic rd_req;
  logic data_wr;
  logic ram_rd_req;
  logic read_mode;
  logic stop_n;
  tcm_state_t state_reg;

  assign req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_req = req && wb_we_i && wb_sel_i[0] && wb_sel_i[1];
  assign rd_req = req && !wb_we_i;
  assign data_wr = wr_req && (wb_adr_i == REG_DATA);
  assign ram_rd_req = rd_req && (wb_adr_i == REG_RAM);
  assign read_mode = !ctrl_reg[WRITE_MODE_BIT];
  assign wb_ack_o = ack_reg;

  // one wait state so ram read data is registered before ack
  always_ff @(posedge sys_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      ack_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= req;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      ctrl_reg <= CTRL_RESET;
    end
    else if (wr_req && wb_adr_i == REG_CTRL)
    begin
      ctrl_reg <= wb_dat_i[15:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      wb_dat_o <= 32'h00000000;
    end
    else if (rd_req)
    begin
      case (wb_adr_i)
        REG_CTRL: wb_dat_o <= {16'h0000, ctrl_reg};
        REG_TRIG_ADDR: wb_dat_o <= {17'h00000, trig_addr_reg};
        REG_STATUS: wb_dat_o <= {26'h0000000, state_reg, level_below, level_above, stop_n};
        REG_POST: wb_dat_o <= {16'h0000, post_reg};
        REG_ADDR: wb_dat_o <= {17'h00000, addr_reg};
        REG_LEVEL: wb_dat_o <= {24'h000000, level_reg};
        REG_RAM: wb_dat_o <= {24'h000000, ram_rd};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // capture sequencing
  // ----------------------------------------------------------------
  logic arm_prev_reg;
  logic rearm;
  assign rearm = ctrl_reg[ARM_BIT] && !arm_prev_reg;
  logic trig_fire;
  assign trig_fire = (state_reg == ST_ARMED) && trigger_in && sample_tick;

  always_ff @(posedge sys_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      arm_prev_reg <= 1'b0;
      state_reg <= ST_READ;
    end
    else
    begin
      arm_prev_reg <= ctrl_reg[ARM_BIT];
      case (state_reg)
        ST_READ:
        begin
          if (!read_mode && rearm)
          begin
            state_reg <= ST_ARMED; // R19
          end
        end
        ST_ARMED:
        begin
          if (read_mode || !ctrl_reg[ARM_BIT])
          begin
            state_reg <= ST_READ;
          end
          else if (trig_fire)
          begin
            state_reg <= ST_POST;
          end
        end
        ST_POST:
        begin
          if (read_mode)
          begin
            state_reg <= ST_READ;
          end
        end
        default: state_reg <= ST_READ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // post-trigger counter
  // ----------------------------------------------------------------
  assign stop_n = (post_reg != POST_TERMINAL); // R6
  assign capture_stop_n = stop_n;
  assign count_run_n = !(state_reg == ST_POST && stop_n); // R7

  always_ff @(posedge sys_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      post_reg <= POST_RESET;
    end
    else if (read_mode && data_wr && !ctrl_reg[POST_LOAD_BIT] && !ctrl_reg[READ_GATE_BIT])
    begin
      post_reg <= wb_dat_i[15:0]; // R2 R3 R14 R21
    end
    else if (!count_run_n && sample_tick)
    begin
      post_reg <= post_reg + 16'h0001; // R1 R4 R5
    end
  end

  // ----------------------------------------------------------------
  // circular address counter and trigger latch
  // ----------------------------------------------------------------
  logic wr_sample;
  logic read_step;
  assign wr_sample = !read_mode && sample_tick && stop_n; // R20
  assign read_step = read_mode && ram_rd_req && !ctrl_reg[MEM_READ_BIT]
    && !ctrl_reg[READ_GATE_BIT];

  always_ff @(posedge sys_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      addr_reg <= ADDR_RESET;
    end
    else if (read_mode && data_wr && !ctrl_reg[ADDR_LOAD_BIT] && !ctrl_reg[READ_GATE_BIT])
    begin
      addr_reg <= wb_dat_i[ADDR_W-1:0]; // R10
    end
    else if ((wr_sample || read_step) && stop_n)
    begin
      addr_reg <= addr_reg + 15'h0001; // R8 R12 R13
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      trig_addr_reg <= ADDR_RESET;
    end
    else if (trig_fire)
    begin
      trig_addr_reg <= addr_reg; // R9
    end
  end
  assign ram_addr = addr_reg;

  // ram read data lands the cycle after the strobe, in time for ack
  tcm_sample_ram #(.AW(ADDR_W), .DW(8)) tcm_sample_ram_i
  (
    .clk(sys_clk),
    .wr_en(wr_sample),
    .addr(addr_reg),
    .wr_data(sample_data),
    .rd_data(ram_rd)
  );

  // ----------------------------------------------------------------
  // video trigger comparator
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      level_reg <= LEVEL_RESET;
    end
    else if (read_mode && wr_req && wb_adr_i == REG_LEVEL)
    begin
      level_reg <= {wb_dat_i[7:LEVEL_LSB], 2'b00}; // R16
    end
  end

  // registered so the trigger generator sees clean edges
  always_ff @(posedge sys_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      level_above <= 1'b0;
      level_below <= 1'b0;
    end
    else
    begin
      level_above <= sample_data > level_reg; // R15 R17 R18
      level_below <= sample_data < level_reg; // R17
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_post_counts: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R4
    (!count_run_n && sample_tick && !data_wr) |=> post_reg == $past(post_reg) + 16'h0001)
    else $error("post counter did not advance");
  a_stop_term: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R6
    (post_reg == POST_TERMINAL) |-> !capture_stop_n)
    else $error("stop not low at terminal count");
  a_stop_run: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R7
    !capture_stop_n |-> count_run_n)
    else $error("run active while stopped");
  a_addr_hold: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R13
    (!capture_stop_n && !data_wr) |=> addr_reg == $past(addr_reg))
    else $error("address moved while stopped");
  a_trig_latch: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R9
    trig_fire |=> trig_addr_reg == $past(addr_reg))
    else $error("trigger address not latched");
  a_read_step: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R12
    (read_step && stop_n && !data_wr) |=> addr_reg == $past(addr_reg) + 15'h0001)
    else $error("no post increment on read");
  a_cmp_equal: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R17
    (sample_data == level_reg) |=> !level_above && !level_below)
    else $error("comparator wrong on equal");
  a_rearm: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R19
    (state_reg == ST_POST) |=> state_reg != ST_ARMED)
    else $error("retriggered without rearm");
  a_post_load: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R3
    (read_mode && data_wr && !ctrl_reg[POST_LOAD_BIT] && !ctrl_reg[READ_GATE_BIT])
    |=> post_reg == $past(wb_dat_i[15:0]))
    else $error("post counter load lost");
  a_arm_edge: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R19
    (state_reg == ST_ARMED && $past(state_reg) != ST_ARMED)
    |-> $past(ctrl_reg[ARM_BIT]) && !$past(ctrl_reg[ARM_BIT], 2))
    else $error("armed without a rising arm bit");
  a_stop_falls: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R6
    (!count_run_n && sample_tick && !data_wr && post_reg == POST_TERMINAL - 16'h0001)
    |=> !capture_stop_n)
    else $error("stop not raised on last count");
  a_write_step: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R20
    (!read_mode && sample_tick && capture_stop_n) |=> addr_reg == $past(addr_reg) + 15'h0001)
    else $error("sample not stepped to next address");
  a_addr_load: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R10
    (read_mode && data_wr && !ctrl_reg[ADDR_LOAD_BIT] && !ctrl_reg[READ_GATE_BIT])
    |=> addr_reg == $past(wb_dat_i[ADDR_W-1:0]))
    else $error("address load lost");
  a_level_latch: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R16
    (read_mode && wr_req && wb_adr_i == REG_LEVEL)
    |=> level_reg == {$past(wb_dat_i[7:LEVEL_LSB]), 2'b00})
    else $error("trigger level not latched");
  a_cmp_above: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R15
    (sample_data > level_reg) |=> level_above && !level_below)
    else $error("comparator wrong above level");
  a_cmp_below: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R17
    (sample_data < level_reg) |=> level_below && !level_above)
    else $error("comparator wrong below level");
endmodule
`default_nettype wire

// [bench/tcm_adc_model.sv]
// sample source model: one tick per sample period, sample value set by the bench
// assumes the capture block samples data and trigger on sample_tick
`timescale 1ns/100ps
`default_nettype none
module tcm_adc_model
#(
  parameter int TICK_DIV = 4
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] level_value,
  output logic sample_tick,
  output logic [7:0] sample_data
);
  // ----------------------------------------
  // sample rate divider
  // ----------------------------------------
  int div_reg;
  // short period keeps capture runs brief; real rates only stretch the same sequence
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_reg <= 0;
      sample_tick <= 1'b0;
    end
    else
    begin
      div_reg <= (div_reg == TICK_DIV - 1) ? 0 : div_reg + 1;
      sample_tick <= (div_reg == TICK_DIV - 1);
    end
  end
  assign sample_data = level_value;
endmodule
`default_nettype wire

// [bench/tcm_capture_bench.sv]
// testbench for tcm_capture: wishbone host tasks and directed checks
// assumes the adc model supplies ticks and samples
`timescale 1ns/100ps
`default_nettype none
module tcm_capture_bench;
  import tcm_pkg::*;
  logic sys_clk = 1'b0, resetn = 1'b0, we = 1'b0, cyc = 1'b0, stb = 1'b0, trig = 1'b0;
  logic [7:0] adr = 8'h00, val = 8'h40;
  logic [31:0] dat = 32'h0, q;
  logic [3:0] sel = 4'hf;
  logic tick, above, below, stop_n, run_n, ack;
  logic [7:0] sd;
  logic [14:0] ram_addr, a;
  logic [31:0] dat_o;
  int fail_count = 0, checks = 0, cyc_count = 0;
  // ----------------------------------------
  // clock, models, design
  // ----------------------------------------
  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end
  tcm_adc_model tcm_adc_model_i (.sys_clk(sys_clk), .resetn(resetn), .level_value(val),
    .sample_tick(tick), .sample_data(sd));
  tcm_capture tcm_capture_i (.sys_clk(sys_clk), .resetn(resetn), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_ack_o(ack), .sample_tick(tick), .sample_data(sd),
    .trigger_in(trig), .level_above(above), .level_below(below),
    .capture_stop_n(stop_n), .count_run_n(run_n), .ram_addr(ram_addr));
  // ----------------------------------------
  // host tasks
  // ----------------------------------------
  task automatic xfer(input logic [7:0] ad, input logic [31:0] d, input logic w);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    dat <= d;
    do @(posedge sys_clk); while (ack !== 1'b1 && cyc_count < 20000);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // load and read gate bits are active low; each call names the bits pulled low, then the bits set high
  task automatic ctl(input logic [15:0] clr, input logic [15:0] set);
    xfer(REG_CTRL, {16'h0, (CTRL_RESET & ~clr) | set}, 1'b1);
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      $display("[ERR] %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc_count++;
    if (cyc_count == 20000)
    begin
      fail_count++;
      finish_test();
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (5) @(posedge sys_clk);
    xfer(REG_STATUS, 32'h0, 1'b0);
    chk("state_stop", {28'h0, q[5:3], q[0]}, 32'h2);
    xfer(REG_POST, 32'h0, 1'b0);
    chk("post_reset", q, 32'hffff);
    ctl(16'h0200, 16'h0);
    xfer(REG_DATA, 32'h1234, 1'b1);
    xfer(REG_POST, 32'h0, 1'b0);
    chk("post_no_load", q, 32'hffff);
    ctl(16'h0280, 16'h0);
    xfer(REG_DATA, 32'hfff0, 1'b1);
    xfer(REG_POST, 32'h0, 1'b0);
    chk("post_load", q, 32'hfff0);
    chk("stop_release", stop_n, 1);
    $display("test load done");
    ctl(16'h0240, 16'h0);
    xfer(REG_DATA, 32'h7ffe, 1'b1);
    chk("addr_load", ram_addr, 15'h7ffe);
    ctl(16'h0600, 16'h0);
    xfer(REG_RAM, 32'h0, 1'b0);
    xfer(REG_RAM, 32'h0, 1'b0);
    chk("addr_wrap", ram_addr, 15'h0000);
    ctl(16'h0280, 16'h0);
    xfer(REG_DATA, 32'hffff, 1'b1);
    ctl(16'h0600, 16'h0);
    xfer(REG_RAM, 32'h0, 1'b0);
    chk("addr_blocked", ram_addr, 15'h0000);
    $display("test ram read done");
    ctl(16'h0, 16'h0);
    xfer(REG_LEVEL, 32'h83, 1'b1);
    xfer(REG_LEVEL, 32'h0, 1'b0);
    chk("level_low_bits", q, 32'h80);
    for (int i = 0; i < 3; i++)
    begin
      val <= (i == 0) ? 8'h81 : (i == 1) ? 8'h7f : 8'h80;
      repeat (4) @(posedge sys_clk);
      chk("compare", {above, below}, (i == 0) ? 2'b10 : (i == 1) ? 2'b01 : 2'b00);
    end
    $display("test comparator done");
    ctl(16'h0280, 16'h0);
    xfer(REG_DATA, 32'hfffc, 1'b1);
    ctl(16'h0240, 16'h0);
    xfer(REG_DATA, 32'h10, 1'b1);
    ctl(16'h0002, 16'h0004);
    ctl(16'h0, 16'h0006);
    trig <= 1'b1;
    for (int i = 0; i < 200 && run_n !== 1'b0; i++) @(posedge sys_clk);
    chk("run_low", run_n, 0);
    for (int i = 0; i < 200 && stop_n !== 1'b0; i++) @(posedge sys_clk);
    trig <= 1'b0;
    chk("stop_low", stop_n, 0);
    a = ram_addr;
    repeat (12) @(posedge sys_clk);
    chk("run_forced", run_n, 1);
    chk("addr_held", ram_addr, a);
    xfer(REG_STATUS, 32'h0, 1'b0);
    chk("state_post", q[5:3], 3'h4);
    xfer(REG_TRIG_ADDR, 32'h0, 1'b0);
    // trigger sample plus three counts from 0xfffc up to terminal
    chk("trig_addr", q[14:0], {17'h0, a - 15'h0004});
    a = q[14:0];
    xfer(REG_POST, 32'h0, 1'b0);
    chk("post_end", q, 32'hffff);
    ctl(16'h0280, 16'h0);
    xfer(REG_DATA, 32'h0, 1'b1);
    chk("stop_reload", stop_n, 1);
    ctl(16'h0240, 16'h0);
    xfer(REG_DATA, {17'h0, a}, 1'b1);
    ctl(16'h0600, 16'h0);
    xfer(REG_RAM, 32'h0, 1'b0);
    chk("ram_data", q, 32'h80);
    chk("ram_step", ram_addr, {17'h0, a + 15'h0001});
    $display("test capture done");
    finish_test();
  end
endmodule
`default_nettype wire
